// ==== hw/rsc_pkg.sv ====
// Constants, types and helpers of the reset and clock control block.
// Assumes a 50 MHz APB clock; offsets are byte addresses on APB.
package rsc_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_MHZ = 50;
	localparam int unsigned RST_HOLD_NS = 100;
	localparam int unsigned RST_HOLD_CYC = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned PLL_LOCK_INIT = 32'h0000_1200;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_BORCTL = 8'h00;
	localparam logic [7:0] OFF_CAUSE = 8'h04;
	localparam logic [7:0] OFF_SRST0 = 8'h08;
	localparam logic [7:0] OFF_CGATE0 = 8'h14;
	localparam logic [7:0] OFF_REGCTL = 8'h20;
	localparam logic [7:0] OFF_RCCFG = 8'h24;
	localparam logic [7:0] OFF_RCCFG_EXT = 8'h28;
	localparam logic [7:0] OFF_SYSRST = 8'h2c;
	localparam logic [7:0] OFF_WDCTL = 8'h30;
	localparam logic [7:0] OFF_WDLOAD = 8'h34;
	localparam logic [7:0] OFF_WDVAL = 8'h38;
	localparam logic [7:0] OFF_STATUS = 8'h3c;
	localparam logic [7:0] OFF_PLLCFG = 8'h40;
	localparam logic [7:0] OFF_LAST = 8'h40;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int unsigned BOR_SEL_BIT = 1;
	localparam int unsigned CAUSE_EXT = 0;
	localparam int unsigned CAUSE_POR = 1;
	localparam int unsigned CAUSE_BOR = 2;
	localparam int unsigned CAUSE_SW = 3;
	localparam int unsigned CAUSE_WDT = 4;
	localparam int unsigned OSC_LSB = 0;
	localparam int unsigned CRYSTAL_SELECT_LSB = 3;
	localparam int unsigned BYPASS_BIT = 8;
	localparam int unsigned PWRDN_BIT = 9;
	localparam int unsigned PWMDIV_LSB = 10;
	localparam int unsigned PWMEN_BIT = 13;
	localparam int unsigned USE_EXT_BIT = 31;
	localparam int unsigned WD_INTEN_BIT = 0;
	localparam int unsigned WD_RESEN_BIT = 1;
	localparam int unsigned WD_INT_BIT = 2;
	localparam int unsigned SYSRST_BIT = 0;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [13:0] RCCFG_RST = 14'h0358;
	localparam logic [13:0] RCCFG_EXT_RST = 14'h0300;
	localparam logic [4:0] CAUSE_RST = 5'h02;
	localparam logic [31:0] WDLOAD_RST = 32'hffff_ffff;
	localparam logic [4:0] REGADJ_RST = 5'h00;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_HOLD = 3'b010,
		ST_REL = 3'b100
	} rsc_state_t;

	typedef enum logic [5:0] {
		SRC_INTERNAL_OSC = 6'h01,
		SRC_MAIN_OSC = 6'h02,
		SRC_IOSC4 = 6'h04,
		SRC_SLOW = 6'h08,
		SRC_RTC = 6'h10,
		SRC_PLL = 6'h20
	} rsc_src_t;

	typedef struct packed {
		logic [2:0] osc_src;
		logic bypass;
		logic pll_pwrdn;
	} rsc_clk_cfg_t;

	// Oscillator field to source; unknown codes fall back to internal_osc
	function automatic rsc_src_t rsc_osc_decode(input logic [2:0] code);
		unique case (code)
			3'h1: return SRC_MAIN_OSC;
			3'h2: return SRC_IOSC4;
			3'h3: return SRC_SLOW;
			3'h4: return SRC_RTC;
			default: return SRC_INTERNAL_OSC;
		endcase
	endfunction : rsc_osc_decode

endpackage : rsc_pkg

// ==== hw/rsc_sync3.sv ====
// Three-stage pin synchroniser with agreement filter.
// Assumes the input is asynchronous to pclk.
`timescale 1ns/10ps
`default_nettype none
module rsc_sync3 #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pin side
	input wire logic [W-1:0] pin,
	// Synchronous side
	output logic [W-1:0] level
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	// Chain; a change is taken once stages two and three agree
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1 <= INIT;
			s2 <= INIT;
			s3 <= INIT;
			level <= INIT;
		end
		else
		begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
			for (int i = 0; i < W; i++)
				if (s2[i] == s3[i])
					level[i] <= s3[i];
		end
	end
endmodule : rsc_sync3
`default_nettype wire

// ==== hw/rsc_xlate_rom.sv ====
// Crystal number to PLL setting table with registered read data.
// Assumes the index is a register of the same clock domain.
`timescale 1ns/10ps
`default_nettype none
module rsc_xlate_rom (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Lookup
	input wire logic [4:0] crystal_select,
	output logic [13:0] pll_setting
);
	// Table entry: {input divider, feedback multiplier}
	function automatic logic [13:0] entry(input logic [4:0] x);
		return {5'(x >> 1), 9'(9'h0c8 - {4'h0, x})};
	endfunction : entry

	// Table read
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pll_setting <= 14'h0000;
		else
			pll_setting <= entry(crystal_select);
	end
endmodule : rsc_xlate_rom
`default_nettype wire

// ==== hw/rsc_ctrl.sv ====
// Reset sequencing, reset cause, peripheral resets, watchdog reset,
// regulator setting and system clock selection, as an APB slave.
// Assumes presetn is the power-on reset and pins are asynchronous.
`timescale 1ns/10ps
`default_nettype none
module rsc_ctrl #(
	parameter int NREG = 3,
	parameter int unsigned LOCK_COUNT = rsc_pkg::PLL_LOCK_INIT
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins
	input wire logic rst_pin_n,
	input wire logic bor_detect,
	input wire logic main_osc_clk,
	// System reset and interrupts
	output logic sys_reset_n,
	output logic bor_irq,
	output logic wdt_irq,
	// Peripheral resets and gates
	output logic [NREG*32-1:0] periph_rst_sys_n,
	output logic [NREG*32-1:0] periph_rst_pwm_n,
	output logic [NREG*32-1:0] periph_clk_en,
	// Clock tree and regulator
	output logic [5:0] clk_sel,
	output logic pll_pwrdn,
	output logic [13:0] pll_setting,
	output logic [4:0] regulator_adjust,
	output logic pwm_clk
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	localparam int NP = NREG * 32;
	localparam logic [12:0] LOCK_INIT = 13'(LOCK_COUNT);
	localparam logic [3:0] HOLD_INIT = 4'(rsc_pkg::RST_HOLD_CYC - 1);

	rsc_pkg::rsc_state_t state;
	rsc_pkg::rsc_state_t next_state;
	rsc_pkg::rsc_clk_cfg_t eff;
	rsc_pkg::rsc_src_t next_clk_sel;
	logic [3:0] hold_cnt;
	logic [3:0] next_hold_cnt;
	logic brownout_reset_select;
	logic [4:0] reset_cause;
	logic [NP-1:0] srst;
	logic [NP-1:0] cgate;
	logic [13:0] rccfg;
	logic [13:0] rccfg_ext;
	logic use_ext;
	logic [1:0] wd_ctl;
	logic wd_int;
	logic [31:0] wd_load;
	logic [31:0] wd_cnt;
	logic [12:0] lock_cnt;
	logic pwrdn_q;
	logic main_osc_q;
	logic [7:0] pwm_cnt;
	logic rst_pin_s;
	logic bor_s;
	logic main_osc_s;
	logic [31:0] rd_mux;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	rsc_sync3 #(.W(3), .INIT(3'b001)) u_sync ( // Pin idles high, no false cause
		.pclk(pclk),
		.presetn(presetn),
		.pin({main_osc_clk, bor_detect, rst_pin_n}),
		.level({main_osc_s, bor_s, rst_pin_s})
	);

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	function automatic logic wr(input logic [7:0] off);
		return psel & penable & pwrite & pready & (paddr == off);
	endfunction : wr

	// Register index of a 32-bit group at base
	function automatic logic grp_hit(input logic [7:0] base, input int i);
		return paddr == 8'(base + 8'(4 * i));
	endfunction : grp_hit

	wire logic setup = psel & ~penable;
	wire logic map_ok = (paddr <= rsc_pkg::OFF_LAST) & (paddr[1:0] == 2'b00);
	wire logic acc_wr = psel & penable & pwrite & pready & map_ok;
	wire logic in_hold = state == rsc_pkg::ST_HOLD;

	// ------------------------------------------------------------
	// Reset sources
	// ------------------------------------------------------------
	// Level sources keep the hold alive; events start it
	wire logic ext_act = ~rst_pin_s;
	wire logic bor_act = bor_s & brownout_reset_select;
	wire logic sw_req = wr(rsc_pkg::OFF_SYSRST) & pwdata[rsc_pkg::SYSRST_BIT];
	wire logic wd_en = wd_ctl[rsc_pkg::WD_INTEN_BIT];
	wire logic wd_zero = wd_cnt == 32'h0000_0000;
	wire logic wd_tick = wd_en & wd_zero & ~in_hold;
	wire logic wdt_fire = wd_tick & wd_int & wd_ctl[rsc_pkg::WD_RESEN_BIT];
	wire logic level_act = ext_act | bor_act;
	wire logic evt_act = sw_req | wdt_fire;
	wire logic [4:0] cause_set = {wdt_fire, sw_req, bor_act, 1'b0, ext_act};

	// ------------------------------------------------------------
	// Reset sequencer
	// ------------------------------------------------------------
	// Hold at least the minimum time, then release for one cycle
	always_comb
	begin
		next_state = state;
		next_hold_cnt = hold_cnt;
		unique case (state)
			rsc_pkg::ST_RUN:
				if (level_act | evt_act)
				begin
					next_state = rsc_pkg::ST_HOLD;
					next_hold_cnt = HOLD_INIT;
				end
			rsc_pkg::ST_HOLD:
				if (level_act)
					next_hold_cnt = HOLD_INIT;
				else if (hold_cnt == 4'h0)
					next_state = rsc_pkg::ST_REL;
				else
					next_hold_cnt = hold_cnt - 4'h1;
			rsc_pkg::ST_REL:
				next_state = rsc_pkg::ST_RUN;
			default:
				next_state = rsc_pkg::ST_HOLD;
		endcase
	end

	// Sequencer state; system reset output follows the hold state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= rsc_pkg::ST_HOLD;
			hold_cnt <= HOLD_INIT;
			sys_reset_n <= 1'b0;
		end
		else
		begin
			state <= next_state;
			hold_cnt <= next_hold_cnt;
			sys_reset_n <= next_state != rsc_pkg::ST_HOLD;
		end
	end

	// ------------------------------------------------------------
	// Brown-out control and reset cause
	// ------------------------------------------------------------
	// Both survive internal resets; power-on leaves only its own bit
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			brownout_reset_select <= 1'b0;
			reset_cause <= rsc_pkg::CAUSE_RST;
			bor_irq <= 1'b0;
		end
		else
		begin
			if (wr(rsc_pkg::OFF_BORCTL))
				brownout_reset_select <= pwdata[rsc_pkg::BOR_SEL_BIT];
			if (wr(rsc_pkg::OFF_CAUSE))
				reset_cause <= (pwdata[4:0] & reset_cause) | cause_set;
			else
				reset_cause <= reset_cause | cause_set;
			bor_irq <= bor_s & ~brownout_reset_select;
		end
	end

	// ------------------------------------------------------------
	// Peripheral resets and gates
	// ------------------------------------------------------------
	// Resets follow the bits; internal reset also hits every peripheral
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			srst <= '0;
			cgate <= '0;
			periph_rst_sys_n <= '0;
			periph_rst_pwm_n <= '0;
			periph_clk_en <= '0;
		end
		else
		begin
			for (int i = 0; i < NREG; i++)
			begin
				if (in_hold)
				begin
					srst[i*32 +: 32] <= 32'h0000_0000;
					cgate[i*32 +: 32] <= 32'h0000_0000;
				end
				else if (acc_wr & grp_hit(rsc_pkg::OFF_SRST0, i))
					srst[i*32 +: 32] <= pwdata;
				else if (acc_wr & grp_hit(rsc_pkg::OFF_CGATE0, i))
					cgate[i*32 +: 32] <= pwdata;
			end
			periph_rst_sys_n <= ~srst & {NP{~in_hold}};
			periph_rst_pwm_n <= ~srst & {NP{~in_hold}};
			periph_clk_en <= cgate;
		end
	end

	// ------------------------------------------------------------
	// Watchdog
	// ------------------------------------------------------------
	// Zero reloads and raises the interrupt; a set beats a clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wd_ctl <= 2'b00;
			wd_int <= 1'b0;
			wd_load <= rsc_pkg::WDLOAD_RST;
			wd_cnt <= rsc_pkg::WDLOAD_RST;
			wdt_irq <= 1'b0;
		end
		else if (in_hold)
		begin
			wd_ctl <= 2'b00;
			wd_int <= 1'b0;
			wd_load <= rsc_pkg::WDLOAD_RST;
			wd_cnt <= rsc_pkg::WDLOAD_RST;
			wdt_irq <= 1'b0;
		end
		else
		begin
			if (wr(rsc_pkg::OFF_WDCTL))
				wd_ctl <= pwdata[1:0];
			if (wr(rsc_pkg::OFF_WDLOAD))
				wd_load <= pwdata;
			if (wr(rsc_pkg::OFF_WDLOAD))
				wd_cnt <= pwdata;
			else if (wd_tick)
				wd_cnt <= wd_load;
			else if (wd_en)
				wd_cnt <= wd_cnt - 32'h0000_0001;
			if (wd_tick)
				wd_int <= 1'b1;
			else if (wr(rsc_pkg::OFF_WDCTL) & pwdata[rsc_pkg::WD_INT_BIT])
				wd_int <= 1'b0;
			wdt_irq <= wd_int | wd_tick;
		end
	end

	// ------------------------------------------------------------
	// Clock configuration and regulator
	// ------------------------------------------------------------
	// Extended fields win while their select bit is set
	assign eff = use_ext ?
		{rccfg_ext[2:0], rccfg_ext[rsc_pkg::BYPASS_BIT], rccfg_ext[rsc_pkg::PWRDN_BIT]} :
		{rccfg[2:0], rccfg[rsc_pkg::BYPASS_BIT], rccfg[rsc_pkg::PWRDN_BIT]};

	wire logic [4:0] crystal_select = rccfg[rsc_pkg::CRYSTAL_SELECT_LSB +: 5];
	wire logic crystal_select_chg = wr(rsc_pkg::OFF_RCCFG) &
		(pwdata[rsc_pkg::CRYSTAL_SELECT_LSB +: 5] != crystal_select);
	wire logic pll_up = pwrdn_q & ~eff.pll_pwrdn;
	wire logic locked = (lock_cnt == 13'h0000) & ~eff.pll_pwrdn;
	wire logic main_osc_rise = main_osc_s & ~main_osc_q;

	// Configuration registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rccfg <= rsc_pkg::RCCFG_RST;
			rccfg_ext <= rsc_pkg::RCCFG_EXT_RST;
			use_ext <= 1'b0;
			regulator_adjust <= rsc_pkg::REGADJ_RST;
		end
		else if (in_hold)
		begin
			rccfg <= rsc_pkg::RCCFG_RST;
			rccfg_ext <= rsc_pkg::RCCFG_EXT_RST;
			use_ext <= 1'b0;
			regulator_adjust <= rsc_pkg::REGADJ_RST;
		end
		else
		begin
			if (wr(rsc_pkg::OFF_RCCFG))
				rccfg <= pwdata[13:0];
			if (wr(rsc_pkg::OFF_RCCFG_EXT))
				rccfg_ext <= pwdata[13:0];
			if (wr(rsc_pkg::OFF_RCCFG_EXT))
				use_ext <= pwdata[rsc_pkg::USE_EXT_BIT];
			if (wr(rsc_pkg::OFF_REGCTL))
				regulator_adjust <= pwdata[4:0];
		end
	end

	// Crystal number to PLL setting
	rsc_xlate_rom u_xlate (
		.pclk(pclk),
		.presetn(presetn),
		.crystal_select(crystal_select),
		.pll_setting(pll_setting)
	);

	// ------------------------------------------------------------
	// PLL lock wait and source selection
	// ------------------------------------------------------------
	// PLL only once the wait has run out; fall back to the oscillator
	assign next_clk_sel = (~eff.bypass & locked) ?
		rsc_pkg::SRC_PLL : rsc_pkg::rsc_osc_decode(eff.osc_src);

	// Lock counter runs on main oscillator edges seen through the sync
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lock_cnt <= LOCK_INIT;
			pwrdn_q <= 1'b1;
			main_osc_q <= 1'b0;
			clk_sel <= rsc_pkg::SRC_INTERNAL_OSC;
			pll_pwrdn <= 1'b1;
		end
		else
		begin
			pwrdn_q <= eff.pll_pwrdn;
			main_osc_q <= main_osc_s;
			if (crystal_select_chg | pll_up)
				lock_cnt <= LOCK_INIT;
			else if (main_osc_rise & (lock_cnt != 13'h0000))
				lock_cnt <= lock_cnt - 13'h0001;
			clk_sel <= next_clk_sel;
			pll_pwrdn <= eff.pll_pwrdn;
		end
	end

	// ------------------------------------------------------------
	// PWM clock
	// ------------------------------------------------------------
	// Toggles every 2^div system cycles, or every cycle when off
	wire logic [7:0] pwm_half = 8'(8'h01 << rccfg[rsc_pkg::PWMDIV_LSB +: 3]);
	wire logic pwm_wrap = ~rccfg[rsc_pkg::PWMEN_BIT] | (pwm_cnt >= pwm_half - 8'h01);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pwm_cnt <= 8'h00;
			pwm_clk <= 1'b0;
		end
		else
		begin
			pwm_cnt <= pwm_wrap ? 8'h00 : pwm_cnt + 8'h01;
			if (pwm_wrap)
				pwm_clk <= ~pwm_clk;
		end
	end

	// ------------------------------------------------------------
	// Read mux and APB answer
	// ------------------------------------------------------------
	// Read data selection for the current address
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		for (int i = 0; i < NREG; i++)
		begin
			if (grp_hit(rsc_pkg::OFF_SRST0, i))
				rd_mux = srst[i*32 +: 32];
			if (grp_hit(rsc_pkg::OFF_CGATE0, i))
				rd_mux = cgate[i*32 +: 32];
		end
		unique case (paddr)
			rsc_pkg::OFF_BORCTL: rd_mux[rsc_pkg::BOR_SEL_BIT] = brownout_reset_select;
			rsc_pkg::OFF_CAUSE: rd_mux[4:0] = reset_cause;
			rsc_pkg::OFF_REGCTL: rd_mux[4:0] = regulator_adjust;
			rsc_pkg::OFF_RCCFG: rd_mux[13:0] = rccfg;
			rsc_pkg::OFF_RCCFG_EXT: rd_mux = {use_ext, 17'h00000, rccfg_ext};
			rsc_pkg::OFF_WDCTL: rd_mux[2:0] = {wd_int, wd_ctl};
			rsc_pkg::OFF_WDLOAD: rd_mux = wd_load;
			rsc_pkg::OFF_WDVAL: rd_mux = wd_cnt;
			rsc_pkg::OFF_STATUS: rd_mux[6:0] = {clk_sel, locked};
			rsc_pkg::OFF_PLLCFG: rd_mux[13:0] = pll_setting;
			default: ;
		endcase
	end

	// Answer prepared in setup, shown in the one-cycle access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			prdata <= (setup & ~pwrite & map_ok) ? rd_mux : 32'h0000_0000;
			pready <= setup;
			pslverr <= setup & ~map_ok;
		end
	end

endmodule : rsc_ctrl
`default_nettype wire

// ==== tb/rsc_ctrl_checker.sv ====
// Port checker of the reset and clock control block.
// Assumes it is bound onto rsc_ctrl.
`timescale 1ns/10ps
`default_nettype none
module rsc_ctrl_checker #(
	parameter int NREG = 3
) (
	// Clock, reset and APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	// Watched outputs
	input wire logic sys_reset_n,
	input wire logic [NREG*32-1:0] periph_rst_sys_n,
	input wire logic [NREG*32-1:0] periph_rst_pwm_n,
	input wire logic [NREG*32-1:0] periph_clk_en,
	input wire logic [5:0] clk_sel,
	input wire logic [4:0] regulator_adjust
);
	logic [31:0] wdata_q;
	wire logic wr = psel && penable && pready && pwrite;
	wire logic cfg = wr && sys_reset_n;
	// Last written word
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wdata_q <= 32'h0000_0000;
		else if (wr)
			wdata_q <= pwdata;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_sysrst;
		wr && paddr == rsc_pkg::OFF_SYSRST && pwdata[0] |=> !sys_reset_n;
	endproperty
	a_sysrst: assert property (p_sysrst) else $error("no system reset");
	property p_hold;
		$fell(sys_reset_n) |-> !sys_reset_n [*5];
	endproperty
	a_hold: assert property (p_hold) else $error("reset too short");
	property p_dom;
		periph_rst_sys_n == periph_rst_pwm_n;
	endproperty
	a_dom: assert property (p_dom) else $error("domain resets differ");
	property p_srst;
		cfg && paddr == rsc_pkg::OFF_SRST0 |-> ##[1:2] periph_rst_sys_n[31:0] == ~wdata_q;
	endproperty
	a_srst: assert property (p_srst) else $error("soft reset wrong");
	property p_gate;
		cfg && paddr == rsc_pkg::OFF_CGATE0 |-> ##[1:2] periph_clk_en[31:0] == wdata_q;
	endproperty
	a_gate: assert property (p_gate) else $error("gate wrong");
	property p_reg;
		cfg && paddr == rsc_pkg::OFF_REGCTL |-> ##[1:2] regulator_adjust == wdata_q[4:0];
	endproperty
	a_reg: assert property (p_reg) else $error("regulator wrong");
	property p_internal_osc;
		!sys_reset_n [*4] |-> clk_sel == 6'h01;
	endproperty
	a_internal_osc: assert property (p_internal_osc) else $error("source not internal");
	property p_onehot;
		$onehot(clk_sel);
	endproperty
	a_onehot: assert property (p_onehot) else $error("source not one-hot");
endmodule : rsc_ctrl_checker
bind rsc_ctrl rsc_ctrl_checker #(.NREG(NREG)) chk_u (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .sys_reset_n(sys_reset_n), .periph_rst_sys_n(periph_rst_sys_n),
	.periph_rst_pwm_n(periph_rst_pwm_n), .periph_clk_en(periph_clk_en), .clk_sel(clk_sel),
	.regulator_adjust(regulator_adjust));
`default_nettype wire

// ==== tb/reset_and_clock_control_tb.sv ====
// Self-checking bench of the reset and clock control block.
// Assumes rsc_pkg, rsc_ctrl and its checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module reset_and_clock_control_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, e, sys_reset_n, bor_irq, wdt_irq, pwm_clk, pll_pwrdn, p;
	int k;
	logic rst_pin_n = 1'b1, bor_detect = 1'b0, main_osc_clk = 1'b0;
	logic [95:0] rs_n, rp_n, cen;
	logic [5:0] clk_sel;
	logic [13:0] pll_setting;
	logic [4:0] regulator_adjust;
	logic [31:0] mdl [0:16];
	int n_errors = 0, check_count = 0, cyc = 0;
	int unsigned x;
	// Clocks and hang limit
	always #10 pclk = ~pclk;
	always #37 main_osc_clk = ~main_osc_clk;
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			n_errors++;
			test_done();
		end
	end
	rsc_ctrl #(.NREG(3), .LOCK_COUNT(16)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rst_pin_n(rst_pin_n), .bor_detect(bor_detect),
		.main_osc_clk(main_osc_clk), .sys_reset_n(sys_reset_n), .bor_irq(bor_irq),
		.wdt_irq(wdt_irq), .periph_rst_sys_n(rs_n), .periph_rst_pwm_n(rp_n),
		.periph_clk_en(cen), .clk_sel(clk_sel), .pll_pwrdn(pll_pwrdn),
		.pll_setting(pll_setting), .regulator_adjust(regulator_adjust), .pwm_clk(pwm_clk));
	task test_done;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One APB transfer, held until pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		mdl[a[7:2]] = d;
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(r, exp);
	endtask : rd
	task wait_rst(input logic lvl);
		int k;
		k = 0;
		while (sys_reset_n !== lvl && k < 400)
		begin
			@(posedge pclk);
			k++;
		end
		chk(sys_reset_n, lvl);
	endtask : wait_rst
	// Expected one-hot source of an oscillator code
	function automatic logic [5:0] src(input int c);
		case (c)
			1: return 6'h02;
			2: return 6'h04;
			3: return 6'h08;
			4: return 6'h10;
			default: return 6'h01;
		endcase
	endfunction : src
	// Main sequence
	initial
	begin
		void'($urandom(32'h1a49));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		wait_rst(1'b1);
		chk(clk_sel, 6'h01);
		rd(rsc_pkg::OFF_BORCTL, 32'h0);
		rd(rsc_pkg::OFF_CAUSE, 32'h2);
		rd(8'h44, 32'h0);
		chk(e, 1'b1);
		for (int i = 0; i < 3; i++)
		begin
			x = $urandom;
			wr(rsc_pkg::OFF_SRST0 + 8'(4 * i), x);
			wr(rsc_pkg::OFF_CGATE0 + 8'(4 * i), ~x);
			repeat (2) @(posedge pclk);
			chk(rs_n[32 * i +: 32], ~mdl[2 + i]);
			chk(rp_n[32 * i +: 32], ~mdl[2 + i]);
			chk(cen[32 * i +: 32], mdl[5 + i]);
			rd(rsc_pkg::OFF_SRST0 + 8'(4 * i), mdl[2 + i]);
			wr(rsc_pkg::OFF_SRST0 + 8'(4 * i), 32'h0);
			repeat (2) @(posedge pclk);
			chk(rs_n[32 * i +: 32], 32'hffff_ffff);
		end
		x = $urandom % 32;
		wr(rsc_pkg::OFF_REGCTL, x);
		repeat (2) @(posedge pclk);
		chk(regulator_adjust, mdl[8]);
		for (int c = 0; c < 6; c++)
		begin
			wr(rsc_pkg::OFF_RCCFG, 32'h0300 | c);
			repeat (2) @(posedge pclk);
			chk(clk_sel, src(c));
		end
		wr(rsc_pkg::OFF_RCCFG_EXT, 32'h8000_0304);
		repeat (2) @(posedge pclk);
		chk(clk_sel, 6'h10);
		wr(rsc_pkg::OFF_RCCFG_EXT, 32'h0300);
		x = 4 + $urandom % 16;
		wr(rsc_pkg::OFF_RCCFG, (x << 3) | 32'h1);
		repeat (2) @(posedge pclk);
		chk(clk_sel, 6'h02);
		repeat (200) @(posedge pclk);
		chk(clk_sel, 6'h20);
		chk(pll_setting, {5'(x >> 1), 9'(200 - x)});
		chk(pll_pwrdn, 1'b0);
		// PWM divider on at divide by four, crystal kept
		wr(rsc_pkg::OFF_RCCFG, (x << 3) | 32'h2401);
		@(posedge pclk);
		p = pwm_clk;
		while (pwm_clk === p)
			@(posedge pclk);
		p = pwm_clk;
		k = 0;
		while (pwm_clk === p)
		begin
			@(posedge pclk);
			k++;
		end
		chk(k, 32'h2);
		chk(clk_sel, 6'h20);
		// Brown-out as interrupt, then as reset
		bor_detect <= 1'b1;
		repeat (10) @(posedge pclk);
		chk(bor_irq, 1'b1);
		chk(sys_reset_n, 1'b1);
		bor_detect <= 1'b0;
		repeat (8) @(posedge pclk);
		wr(rsc_pkg::OFF_BORCTL, 32'h2);
		bor_detect <= 1'b1;
		wait_rst(1'b0);
		repeat (40) @(posedge pclk);
		chk(sys_reset_n, 1'b0);
		chk(rs_n[95:64], 32'h0);
		bor_detect <= 1'b0;
		wait_rst(1'b1);
		chk(regulator_adjust, 5'h00);
		rd(rsc_pkg::OFF_CAUSE, 32'h6);
		wr(rsc_pkg::OFF_CAUSE, 32'h0);
		wr(rsc_pkg::OFF_SYSRST, 32'h1);
		wait_rst(1'b0);
		wait_rst(1'b1);
		rd(rsc_pkg::OFF_CAUSE, 32'h8);
		// Watchdog: interrupt only, then reset on second zero
		wr(rsc_pkg::OFF_WDLOAD, 32'd20);
		wr(rsc_pkg::OFF_WDCTL, 32'h1);
		repeat (30) @(posedge pclk);
		chk(wdt_irq, 1'b1);
		apb(1'b0, rsc_pkg::OFF_WDVAL, 32'h0);
		chk(32'(r <= 32'd20), 32'h1);
		repeat (30) @(posedge pclk);
		chk(sys_reset_n, 1'b1);
		wr(rsc_pkg::OFF_WDCTL, 32'h7);
		wait_rst(1'b0);
		wait_rst(1'b1);
		rd(rsc_pkg::OFF_CAUSE, 32'h18);
		// External reset pin pulse
		rst_pin_n <= 1'b0;
		wait_rst(1'b0);
		rst_pin_n <= 1'b1;
		wait_rst(1'b1);
		rd(rsc_pkg::OFF_CAUSE, 32'h19);
		test_done();
	end
endmodule : reset_and_clock_control_tb
`default_nettype wire
